// file: logic/sapc_pkg.sv
// package for the sar converter power and short-cycle control block
// assumes a 50 MHz system clock sampling the serial clock and select pins
`default_nettype none
package sapc_pkg;
  localparam int unsigned SAPC_CLK_HZ = 50000000;
  localparam int unsigned SAPC_RES_BITS = 12;
  // one decision per serial clock: 312 ns at 200 kHz sample rate
  localparam int unsigned SAPC_DECISION_NS = 312;
  localparam int unsigned SAPC_SAMPLE_KHZ = 200;
  localparam int unsigned SAPC_CLK_NS = 1000000000 / SAPC_CLK_HZ;
  localparam int unsigned SAPC_DECISION_CYC =
    (SAPC_DECISION_NS / SAPC_CLK_NS) < 1 ? 1 :
    (SAPC_DECISION_NS / SAPC_CLK_NS);
  // falling edges of the serial clock at which phases change
  localparam logic [4:0] SAPC_EDGE_ENABLE = 5'h02;
  localparam logic [4:0] SAPC_EDGE_MSB = 5'h03;
  localparam logic [4:0] SAPC_EDGE_LSB = 5'h0e;
  localparam logic [4:0] SAPC_EDGE_REPEND = 5'h19;
  localparam logic [11:0] SAPC_CODE_POS_FS = 12'h7ff;
  localparam logic [11:0] SAPC_CODE_MID = 12'h000;
  localparam logic [11:0] SAPC_CODE_NEG_FS = 12'h800;

  typedef enum logic [2:0] {
    SAPC_OFF  = 3'b000,
    SAPC_SAMP = 3'b001,
    SAPC_ZERO = 3'b011,
    SAPC_CONV = 3'b010,
    SAPC_REP  = 3'b110,
    SAPC_DONE = 3'b111
  } sapc_state_t;

  typedef struct packed {
    logic analogOn;
    logic digitalOn;
  } sapc_power_t;

  typedef struct packed {
    logic data;
    logic oe;
  } sapc_dout_t;
endpackage
`default_nettype wire

// file: logic/sapc_sync.sv
// two-flop synchroniser for a group of pins
// assumes the inputs are asynchronous to clk
`default_nettype none
module sapc_sync #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule
`default_nettype wire

// file: logic/sapc_ctrl.sv
// serial converter control: power states, short cycling, bit stream
// assumes serial clock and select arrive asynchronously and are
// sampled by clk; the comparator decision comes from the analog core
// Contract
// - analog powers down after conversion or select high
// - digital powers down only while select high
// - analog stays on from start until power-down
// - each decided bit driven out immediately
// - select high abandons conversion, full power-down
// - one bit decision per serial clock
// - select falling edge starts; needs high first (code also starts a frame when select is already low at reset release)
// - low bit, then 12 bits msb first
// - repeat lsb first, then tri-state, ignore clocks
// - result is two's complement code
`default_nettype none
module sapc_ctrl
  import sapc_pkg::*;
#(
  parameter int unsigned RES_BITS = SAPC_RES_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serialClock,
  input wire logic selectN,
  input wire logic compDecision,
  output logic serialData,
  output logic serialDataOe,
  output logic analogPowerOn,
  output logic digitalPowerOn,
  output logic sampleHold,
  output logic [RES_BITS-1:0] resultCode
);
  logic [1:0] pinSync;
  logic sclkS;
  logic selNS;

  // select resets high, so a select already low at reset release reads as a falling edge and starts a frame
  sapc_sync #(.W(2), .INIT(2'b11)) uSync (
    .clk(clk),
    .resetn(resetn),
    .din({selectN, serialClock}),
    .dout(pinSync)
  );
  assign sclkS = pinSync[0];
  assign selNS = pinSync[1];

  sapc_state_t state_ff, nxt_state;
  logic sclkPrev_ff, nxt_sclkPrev;
  logic selPrev_ff, nxt_selPrev;
  logic [4:0] edgeCnt_ff, nxt_edgeCnt;
  logic [RES_BITS-1:0] sar_ff, nxt_sar;
  logic [3:0] bitIdx_ff, nxt_bitIdx;
  sapc_dout_t dout_ff, nxt_dout;
  sapc_power_t pwr_ff, nxt_pwr;
  logic samp_ff, nxt_samp;
  logic sclkFall;
  logic selFall;
  logic frameStart;
  logic enableEdge;
  logic lsbEdge;

  // edge detectors; select history resets high, its idle pin level,
  // so releasing reset with select already low gives a select fall and starts a frame
  always_comb begin
    nxt_sclkPrev = sclkS;
    nxt_selPrev = selNS;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkPrev_ff <= 1'b0;
      selPrev_ff <= 1'b1;
    end else begin
      sclkPrev_ff <= nxt_sclkPrev;
      selPrev_ff <= nxt_selPrev;
    end
  end

  assign sclkFall = sclkPrev_ff & ~sclkS;
  assign selFall = selPrev_ff & ~selNS;
  // events shared by the sequencer, power and sample groups
  assign frameStart = (state_ff == SAPC_OFF) & selFall;
  assign enableEdge = (state_ff == SAPC_SAMP) & sclkFall &
    (edgeCnt_ff + 5'h01 == SAPC_EDGE_ENABLE);
  assign lsbEdge = ((state_ff == SAPC_ZERO) | (state_ff == SAPC_CONV)) &
    sclkFall & (bitIdx_ff == 4'h0);

  // power follows the frame; a short cycle drops both at once
  always_comb begin
    nxt_pwr = pwr_ff;
    if (selNS) begin
      nxt_pwr = '0;
    end else if (frameStart) begin
      nxt_pwr = '{analogOn: 1'b1, digitalOn: 1'b1};
    end else if (lsbEdge) begin
      // analog idles once the lsb is decided; digital waits for select
      nxt_pwr.analogOn = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // sample phase runs from the select fall to the second serial fall
  always_comb begin
    nxt_samp = samp_ff;
    if (selNS) begin
      nxt_samp = 1'b0;
    end else if (frameStart) begin
      nxt_samp = 1'b1;
    end else if (enableEdge) begin
      nxt_samp = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_ff <= 1'b0;
    end else begin
      samp_ff <= nxt_samp;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_edgeCnt = edgeCnt_ff;
    nxt_sar = sar_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_dout = dout_ff;
    if (selNS) begin
      // short cycle: abandon everything
      nxt_state = SAPC_OFF;
      nxt_dout = '{data: 1'b0, oe: 1'b0};
      nxt_edgeCnt = 5'h00;
    end else begin
      case (state_ff)
        SAPC_OFF: begin
          if (frameStart) begin
            nxt_state = SAPC_SAMP;
            nxt_edgeCnt = 5'h00;
            nxt_sar = SAPC_CODE_MID;
          end
        end
        SAPC_SAMP: begin
          if (sclkFall) begin
            nxt_edgeCnt = edgeCnt_ff + 5'h01;
            if (enableEdge) begin
              nxt_state = SAPC_ZERO;
              nxt_dout = '{data: 1'b0, oe: 1'b1};
              nxt_bitIdx = 4'(RES_BITS - 1);
            end
          end
        end
        SAPC_ZERO, SAPC_CONV: begin
          if (sclkFall) begin
            // one decision per falling edge, driven at once
            nxt_edgeCnt = edgeCnt_ff + 5'h01;
            nxt_sar[bitIdx_ff] = compDecision;
            nxt_dout = '{data: compDecision, oe: 1'b1};
            if (lsbEdge) begin
              nxt_state = SAPC_REP;
              nxt_bitIdx = 4'h1;
            end else begin
              nxt_state = SAPC_CONV;
              nxt_bitIdx = bitIdx_ff - 4'h1;
            end
          end
        end
        SAPC_REP: begin
          if (sclkFall) begin
            nxt_edgeCnt = edgeCnt_ff + 5'h01;
            if (edgeCnt_ff == SAPC_EDGE_REPEND) begin
              // msb repeated: tri-state, ignore clocks
              nxt_state = SAPC_DONE;
              nxt_dout = '{data: 1'b0, oe: 1'b0};
            end else begin
              nxt_dout.data = sar_ff[bitIdx_ff];
              nxt_bitIdx = bitIdx_ff + 4'h1;
            end
          end
        end
        // digital stays on while select low, clocks ignored
        SAPC_DONE: nxt_state = SAPC_DONE;
        default: nxt_state = SAPC_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SAPC_OFF;
      edgeCnt_ff <= 5'h00;
      sar_ff <= '0;
      bitIdx_ff <= 4'h0;
      dout_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      edgeCnt_ff <= nxt_edgeCnt;
      sar_ff <= nxt_sar;
      bitIdx_ff <= nxt_bitIdx;
      dout_ff <= nxt_dout;
    end
  end

  assign serialData = dout_ff.data;
  assign serialDataOe = dout_ff.oe;
  assign analogPowerOn = pwr_ff.analogOn;
  assign digitalPowerOn = pwr_ff.digitalOn;
  assign sampleHold = samp_ff;
  assign resultCode = sar_ff;
endmodule
`default_nettype wire

// file: verif/sapc_ctrl_monitor.sv
// checker on the block pins; select holds 8 clk around each change
`default_nettype none
module sapc_ctrl_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic selectN,
  input wire logic serialData,
  input wire logic serialDataOe,
  input wire logic analogPowerOn,
  input wire logic digitalPowerOn,
  input wire logic sampleHold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_start_power: assert property ($fell(selectN) |-> ##[1:5]
    (analogPowerOn && sampleHold)) else $error("no start");
  a_idle_quiet: assert property (selectN[*4] |->
    !(digitalPowerOn || serialDataOe)) else $error("not idle");
  a_dig_stays: assert property ((!selectN)[*4] ##0 digitalPowerOn
    |=> digitalPowerOn) else $error("digital off");
  a_lead_low: assert property ($rose(serialDataOe) |-> !serialData)
    else $error("lead bit");
  a_bit_hold: assert property ($changed(serialData) |=>
    $stable(serialData)[*4]) else $error("bit hold");
  a_done_power: assert property ($fell(serialDataOe) && !selectN
    |-> !analogPowerOn && digitalPowerOn) else $error("done power");
  a_power_pair: assert property (analogPowerOn |-> digitalPowerOn)
    else $error("power pair");
  a_analog_hold: assert property ($fell(analogPowerOn) |->
    serialDataOe || $past(selectN)) else $error("analog drop");
endmodule
bind sapc_ctrl sapc_ctrl_monitor mon (.*);
`default_nettype wire

// file: verif/sapc_host_model.sv
// host on the pins; serial clock idles high so frames stand apart
`default_nettype none
module sapc_host_model (
  input wire logic clk,
  input wire logic serialData,
  input wire logic serialDataOe,
  output logic serialClock,
  output logic selectN,
  output logic compDecision
);
  timeunit 1ns / 1ns;
  logic [30:1] dq, oq;
  int k;
  initial {serialClock, selectN, compDecision} = 3'b110;
  task automatic sel(input logic v);
    @(posedge clk) selectN <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic clocks(input int n, half, input logic [11:0] c);
    for (k = 1; k <= n; k++) begin
      @(posedge clk) serialClock <= 1'b0;
      compDecision <= (k > 2 && k < 15) ? c[14-k] : ~compDecision;
      repeat (half) @(posedge clk);
      serialClock <= 1'b1;
      {dq[k], oq[k]} = {serialData, serialDataOe};
      repeat (half) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: verif/sapc_ctrl_tb.sv
// bench for sapc_ctrl; host model drives pins, monitor is bound in
`default_nettype none
module sapc_ctrl_tb import sapc_pkg::*; ;
  timeunit 1ns / 1ns;
  logic clk = 1'b0, resetn = 1'b0;
  logic serialClock, selectN, compDecision, serialData, serialDataOe;
  logic analogPowerOn, digitalPowerOn, sampleHold;
  logic [11:0] resultCode;
  logic [11:0] codes [4] = '{12'h7ff, 12'h000, 12'h800, 12'ha5c};
  wire logic [2:0] pwr = {analogPowerOn, digitalPowerOn, serialDataOe};
  int fails = 0, num_checks = 0;
  always #10 clk = ~clk;
  sapc_ctrl dut (
    .clk(clk),
    .resetn(resetn),
    .serialClock(serialClock),
    .selectN(selectN),
    .compDecision(compDecision),
    .serialData(serialData),
    .serialDataOe(serialDataOe),
    .analogPowerOn(analogPowerOn),
    .digitalPowerOn(digitalPowerOn),
    .sampleHold(sampleHold),
    .resultCode(resultCode)
  );
  sapc_host_model host (
    .clk(clk),
    .serialData(serialData),
    .serialDataOe(serialDataOe),
    .serialClock(serialClock),
    .selectN(selectN),
    .compDecision(compDecision)
  );
  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    fails += int'(got !== exp);
    if (got !== exp) $display("BAD %s exp %h got %h", what, exp, got);
  endtask
  task automatic t_full(input logic [11:0] c);
    host.sel(1'b0);
    host.clocks(30, 4, c);
    chk("oe", 30'h1fffffe, host.oq);
    chk("bits", {5'h00, c[11:1], {<<{c}}, 2'b00},
      host.dq & host.oq);
    chk("pwr", 3'b010, pwr);
    chk("code", c, resultCode);
    host.sel(1'b1);
    $display("t_full %h done", c);
  endtask
  task automatic t_short(input logic [11:0] c);
    host.sel(1'b0);
    host.clocks(6, 8, c);
    chk("pwr", 3'b111, pwr);
    chk("code", {c[11:8], 8'h00}, resultCode);
    chk("bits", {{<<{c[11:8]}}, 2'b00},
      host.dq[6:1] & host.oq[6:1]);
    host.sel(1'b1);
    $display("t_short %h done", c);
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100us fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pwr", 3'b000, pwr);
    foreach (codes[i]) t_full(codes[i]);
    t_short(12'h5a3);
    give_verdict();
  end
endmodule
`default_nettype wire
